// *** logic/pgfs_pkg.sv ***
// constants for the power-good and fault supervisor
package pgfs_pkg;
    localparam int DW = 8;
    localparam int AW = 8;
    // register offsets
    localparam logic [AW-1:0] ADDR_FAULT   = 8'h00;
    localparam logic [AW-1:0] ADDR_STATUS  = 8'h01;
    localparam logic [AW-1:0] ADDR_RO_LAST = 8'h03;
    localparam logic [AW-1:0] ADDR_TRIP    = 8'h04;
    localparam logic [AW-1:0] ADDR_MASK    = 8'h14;
    localparam logic [AW-1:0] ADDR_CTRL    = 8'h22;
    // fault flag bit positions
    localparam int FB_OV    = 0;
    localparam int FB_SC    = 1;
    localparam int FB_HS    = 2;
    localparam int FB_THERM = 3;
    localparam int FB_VDR   = 4;
    // status layout
    localparam int NCH        = 4;
    localparam int NEXT       = 2;
    localparam int ST_EXT_LSB = 4;
    localparam int ST_RANGE_W = 6;
    localparam int ST_SUMMARY = 7;
    // control bit: 0 open drain, 1 driven output
    localparam int CTRL_PUSH_PULL = 3;
    // nonvolatile defaults
    localparam logic [DW-1:0] MASK_RESET_DEF = 8'h00;
    localparam logic [DW-1:0] CTRL_RESET_DEF = 8'h00;
    localparam logic [DW-1:0] ZERO_BYTE      = 8'h00;
    localparam int NCS_DEF = 3;
endpackage

// *** logic/pgfs_supervisor.sv ***
// power-good status, sticky fault flags and channel shutdown control
`timescale 1ns/10ps
`default_nettype none
module pgfs_supervisor
#(
    parameter int                     NCS        = pgfs_pkg::NCS_DEF,
    parameter logic [pgfs_pkg::DW-1:0] MASK_RESET = pgfs_pkg::MASK_RESET_DEF,
    parameter logic [pgfs_pkg::DW-1:0] CTRL_RESET = pgfs_pkg::CTRL_RESET_DEF
)
(
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      ce,
    // asynchronous pins and comparators
    input  wire logic                      global_en_pin,
    input  wire logic [pgfs_pkg::NCH-1:0]  ch_above_hi,
    input  wire logic [pgfs_pkg::NCH-1:0]  ch_below_lo,
    input  wire logic [pgfs_pkg::NEXT-1:0] ext_above_thr,
    input  wire logic [pgfs_pkg::NCH-1:0]  ov_detect,
    input  wire logic [pgfs_pkg::NCH-1:0]  sc_detect,
    input  wire logic [pgfs_pkg::NCH-1:0]  hs_detect,
    input  wire logic                      thermal_hot,
    input  wire logic                      drive_rail_low,
    input  wire logic [NCS-1:0]            oc_detect,
    // sequencer and enable logic, same clock
    input  wire logic                      seq_done,
    input  wire logic                      seq_blank,
    input  wire logic [pgfs_pkg::NCH-1:0]  ch_enable,
    input  wire logic [pgfs_pkg::NEXT-1:0] ext_enable,
    input  wire logic [NCS-1:0]            cs_enable,
    input  wire logic [1:0]                aon_enable,
    // register port from the serial engine
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    input  wire logic [pgfs_pkg::AW-1:0]   reg_addr,
    input  wire logic [pgfs_pkg::DW-1:0]   reg_wdata,
    output logic      [pgfs_pkg::DW-1:0]   reg_rdata,
    output logic                           reg_ack,
    // power-ok pin
    output logic                           power_ok_output,
    output logic                           power_ok_oe_n,
    // channel run controls
    output logic      [pgfs_pkg::NCH-1:0]  ch_run,
    output logic      [pgfs_pkg::NEXT-1:0] ext_run,
    output logic      [NCS-1:0]            cs_run,
    output logic      [1:0]                aon_run
);
    import pgfs_pkg::*;

    if (NCS < 1 || NCS > DW) begin : g_chk
        $error("NCS must be 1 to 8");
    end

    // two-flop synchronisers
    logic                en_m, en_s;
    logic [NCH-1:0]      hi_m, hi_s, lo_m, lo_s;
    logic [NEXT-1:0]     ex_m, ex_s;
    logic [NCH-1:0]      ov_m, ov_s, sc_m, sc_s, hs_m, hs_s;
    logic                th_m, th_s, vd_m, vd_s;
    logic [NCS-1:0]      oc_m, oc_s;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {en_m, en_s, th_m, th_s, vd_m, vd_s} <= '0;
            {hi_m, hi_s, lo_m, lo_s, ex_m, ex_s} <= '0;
            {ov_m, ov_s, sc_m, sc_s, hs_m, hs_s} <= '0;
            {oc_m, oc_s} <= '0;
        end else if (ce) begin
            en_m <= global_en_pin;
            en_s <= en_m;
            hi_m <= ch_above_hi;
            hi_s <= hi_m;
            lo_m <= ch_below_lo;
            lo_s <= lo_m;
            ex_m <= ext_above_thr;
            ex_s <= ex_m;
            ov_m <= ov_detect;
            ov_s <= ov_m;
            sc_m <= sc_detect;
            sc_s <= sc_m;
            hs_m <= hs_detect;
            hs_s <= hs_m;
            th_m <= thermal_hot;
            th_s <= th_m;
            vd_m <= drive_rail_low;
            vd_s <= vd_m;
            oc_m <= oc_detect;
            oc_s <= oc_m;
        end
    end

    // register state
    logic [DW-1:0]  mask;
    logic [DW-1:0]  ctrl;
    logic [NCH-1:0] ch_in_range;
    logic [NCH-1:0] ov_rec, sc_rec, hs_rec;
    logic           therm_flag, vdr_flag;
    logic [NCS-1:0] trip;

    logic wr_fault, wr_trip, wr_ro, vdr_cause;
    assign wr_fault = reg_wr && (reg_addr == ADDR_FAULT);
    assign wr_trip  = reg_wr && (reg_addr == ADDR_TRIP);
    assign wr_ro    = reg_wr && (reg_addr >= ADDR_STATUS) && (reg_addr <= ADDR_RO_LAST);
    assign vdr_cause = vd_s && en_s;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask <= MASK_RESET;
            ctrl <= CTRL_RESET;
        end else if (ce && reg_wr) begin
            if (reg_addr == ADDR_MASK) begin
                mask <= reg_wdata;
            end
            if (reg_addr == ADDR_CTRL) begin
                ctrl <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ch_in_range <= '0;
        end else if (ce) begin
            ch_in_range <= (ch_in_range & ~lo_s) | hi_s;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ov_rec <= '0;
            sc_rec <= '0;
            hs_rec <= '0;
        end else if (ce) begin
            ov_rec <= (ov_rec & ~{NCH{wr_fault && reg_wdata[FB_OV]}}) | ov_s;
            sc_rec <= (sc_rec & ~{NCH{wr_fault && reg_wdata[FB_SC]}}) | sc_s;
            hs_rec <= (hs_rec & ~{NCH{wr_fault && reg_wdata[FB_HS]}}) | hs_s;
        end
    end

    // live cause re-sets the flag, so a clear is refused
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            therm_flag <= 1'b0;
            vdr_flag   <= 1'b0;
        end else if (ce) begin
            therm_flag <= (therm_flag && !(wr_fault && reg_wdata[FB_THERM])) || th_s;
            vdr_flag   <= (vdr_flag && !(wr_fault && reg_wdata[FB_VDR])) || vdr_cause;
        end
    end

    // sticky trip flags, write one clears
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trip <= '0;
        end else if (ce) begin
            trip <= (trip & ~({NCS{wr_trip}} & reg_wdata[NCS-1:0])) | (oc_s & {NCS{en_s}});
        end
    end

    // status and fault views
    logic [DW-1:0] fault_view, status_view, trip_view;
    logic [ST_RANGE_W-1:0] range_eff;
    logic global_flt, any_fault, pok_level, push_pull;
    logic [NCH-1:0] chan_shut;

    assign range_eff = {ex_s, ch_in_range} | mask[ST_RANGE_W-1:0];
    always_comb begin
        status_view = ZERO_BYTE;
        status_view[ST_RANGE_W-1:0] = range_eff;
        status_view[ST_SUMMARY] = &range_eff;
    end
    always_comb begin
        fault_view = ZERO_BYTE;
        fault_view[FB_OV]    = |ov_rec;
        fault_view[FB_SC]    = |sc_rec;
        fault_view[FB_HS]    = |hs_rec;
        fault_view[FB_THERM] = therm_flag;
        fault_view[FB_VDR]   = vdr_flag;
    end
    always_comb begin
        trip_view = ZERO_BYTE;
        trip_view[NCS-1:0] = trip;
    end

    assign global_flt = therm_flag || vdr_flag;
    assign any_fault  = (fault_view != ZERO_BYTE);
    assign chan_shut  = ov_rec | sc_rec | hs_rec;
    // blanked during delays and soft start
    assign pok_level  = en_s && seq_done && !seq_blank && !any_fault && status_view[ST_SUMMARY];
    assign push_pull  = ctrl[CTRL_PUSH_PULL];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            power_ok_output <= 1'b0;
            power_ok_oe_n   <= 1'b0;
        end else if (ce) begin
            power_ok_output <= push_pull && pok_level;
            power_ok_oe_n   <= !push_pull && (pok_level || !en_s);
        end
    end

    // run again once records clear, enable high
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ch_run  <= '0;
            ext_run <= '0;
        end else if (ce) begin
            ch_run  <= ch_enable & {NCH{en_s && !global_flt}} & ~chan_shut;
            ext_run <= ext_enable & {NEXT{en_s && !global_flt && (chan_shut == '0)}};
        end
    end

    // global faults stop the load switches too
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_run  <= '0;
            aon_run <= '0;
        end else if (ce) begin
            cs_run  <= cs_enable & ~trip & {NCS{!global_flt}};
            aon_run <= aon_enable;
        end
    end

    // register reads and acknowledge
    // no ack on read-only writes
    // access stays live in every fault state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= ZERO_BYTE;
            reg_ack   <= 1'b0;
        end else if (ce) begin
            reg_ack <= (reg_wr && !wr_ro) || reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    ADDR_FAULT:  reg_rdata <= fault_view;
                    ADDR_STATUS: reg_rdata <= status_view;
                    ADDR_TRIP:   reg_rdata <= trip_view;
                    ADDR_MASK:   reg_rdata <= mask;
                    ADDR_CTRL:   reg_rdata <= ctrl;
                    default:     reg_rdata <= ZERO_BYTE;
                endcase
            end
        end
    end

    // checks
    sequence s_therm_clear_live;
        ce && th_s && wr_fault && reg_wdata[FB_THERM];
    endsequence
    sequence s_ov_clear_calm;
        ce && en_s && !global_flt && wr_fault && reg_wdata[FB_OV] && ov_s == '0
            && sc_rec == '0 && hs_rec == '0 && sc_s == '0 && hs_s == '0 && ch_enable == '1;
    endsequence

    AST_TRIP_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
        ce && trip[0] && !wr_trip |=> trip[0])
        else $error("trip flag dropped without clear");
    AST_GLOBAL_REFUSE: assert property (@(posedge clk) disable iff (sys_rst)
        s_therm_clear_live |=> therm_flag)
        else $error("thermal clear accepted while hot");
    AST_SET_WINS: assert property (@(posedge clk) disable iff (sys_rst)
        ce && oc_s[0] && en_s && wr_trip && reg_wdata[0] |=> trip[0])
        else $error("clear beat a simultaneous set");
    AST_FAULT_POK: assert property (@(posedge clk) disable iff (sys_rst)
        ce && any_fault |=> !power_ok_output && (push_pull || !power_ok_oe_n || !en_s))
        else $error("power ok shown under fault");
    AST_GLOBAL_SHUT: assert property (@(posedge clk) disable iff (sys_rst)
        ce && global_flt |=> ch_run == '0 && ext_run == '0)
        else $error("channel running in global fault");
    AST_RO_NOACK: assert property (@(posedge clk) disable iff (sys_rst)
        ce && wr_ro && !reg_rd |=> !reg_ack)
        else $error("write to read-only offset acknowledged");
    AST_OD_EN_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        ce && !en_s && !push_pull |=> power_ok_oe_n && !power_ok_output)
        else $error("open drain pin not released with enable low");
    AST_HYST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        ce && ch_in_range[0] && !lo_s[0] |=> ch_in_range[0])
        else $error("in-range dropped above low level");
    AST_MASK_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
        mask[0] |-> status_view[0])
        else $error("masked bit reads low");
    AST_RESTART: assert property (@(posedge clk) disable iff (sys_rst)
        s_ov_clear_calm ##1 ce |=> ch_run == '1)
        else $error("channel not restarted after clear");

    // trip clear with no live over-current; cause sampled before the clear edge
    sequence s_trip_clear_calm;
        ce && !global_flt && wr_trip && reg_wdata[0] && !oc_s[0] && cs_enable[0];
    endsequence

    AST_CS_RESTART: assert property (@(posedge clk) disable iff (sys_rst)
        s_trip_clear_calm ##1 (ce && !global_flt && cs_enable[0]) |=> cs_run[0])
        else $error("current-sense channel not restarted after clear");
    AST_CS_GLOBAL_SHUT: assert property (@(posedge clk) disable iff (sys_rst)
        ce && global_flt |=> cs_run == '0)
        else $error("load switch running in global fault");
    AST_AON_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
        ce |=> aon_run == $past(aon_enable))
        else $error("always-on regulator disturbed");
    AST_ACK_READ: assert property (@(posedge clk) disable iff (sys_rst)
        ce && reg_rd |=> reg_ack)
        else $error("read not acknowledged");
    AST_TRIP_OWN: assert property (@(posedge clk) disable iff (sys_rst)
        ce && trip[0] |=> !cs_run[0])
        else $error("tripped channel still running");
    AST_POK_BLANK: assert property (@(posedge clk) disable iff (sys_rst)
        ce && seq_blank |=> !power_ok_output)
        else $error("power ok driven during blanking");
    AST_POK_NEEDS_EN: assert property (@(posedge clk) disable iff (sys_rst)
        ce && !en_s |=> !power_ok_output)
        else $error("power ok driven with enable low");
    AST_VDR_GATED: assert property (@(posedge clk) disable iff (sys_rst)
        ce && !en_s && !vdr_flag |=> !vdr_flag)
        else $error("drive-rail flag set with enable low");
    AST_THERM_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        ce && therm_flag && !wr_fault |=> therm_flag)
        else $error("thermal flag cleared without write");
    AST_PP_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
        ce && push_pull |=> !power_ok_oe_n)
        else $error("driven mode pin not driven");
    AST_OD_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        ce && !push_pull && en_s && !pok_level |=> !power_ok_oe_n && !power_ok_output)
        else $error("open drain pin not pulled low");
    AST_MASK_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        ce && reg_wr && reg_addr == ADDR_MASK |=> mask == $past(reg_wdata))
        else $error("mask write lost");
endmodule
`default_nettype wire

// *** test/pgfs_host_model.sv ***
// serial-engine side model driving the register port
`timescale 1ns/10ps
`default_nettype none
module pgfs_host_model (
    // clock
    input  wire logic                    clk,
    // register port
    output logic                         reg_wr,
    output logic                         reg_rd,
    output logic [pgfs_pkg::AW-1:0]      reg_addr,
    output logic [pgfs_pkg::DW-1:0]      reg_wdata,
    input  wire logic                    reg_ack,
    input  wire logic [pgfs_pkg::DW-1:0] reg_rdata
);
    import pgfs_pkg::*;
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'hFF;
        reg_wdata = 8'hFF;
    end
    // one-cycle strobe; a missing ack means refused
    task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                        output logic ok, output logic [DW-1:0] q);
        @(posedge clk);
        reg_wr    <= w;
        reg_rd    <= ~w;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        // released lines never keep the old value
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        #1;
        ok = (reg_ack === 1'b1);
        q  = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the power-good and fault supervisor
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pgfs_pkg::*;
    localparam int NC = 3;
    logic          clk = 1'b0, sys_rst = 1'b1, en = 1'b0, hot = 1'b0, vlow = 1'b0;
    logic          sdone = 1'b0, sblank = 1'b0, pp = 1'b0, ok;
    logic          ce_in = 1'b1;
    logic [3:0]    hi = 4'h0, lo = 4'hF, ov = 4'h0, sc = 4'h0, hs = 4'h0, chen = 4'hF, st = 4'h0;
    logic [1:0]    ext = 2'h0, exen = 2'h3, aon = 2'h3, c, xrun, arun;
    logic [NC-1:0] oc = 3'h0, csen = 3'h7, csrun;
    logic          rwr, rrd, ack, pout, poe_n;
    logic [7:0]    radr, rwd, rdat, q;
    logic [3:0]    crun;
    logic [5:0]    m;
    logic [31:0]   seed = 32'h4348;
    int            err_total = 0, compares = 0;
    always #4 clk = ~clk;
    pgfs_host_model u_host (.clk(clk), .reg_wr(rwr), .reg_rd(rrd), .reg_addr(radr),
        .reg_wdata(rwd), .reg_ack(ack), .reg_rdata(rdat));
    pgfs_supervisor #(.NCS(NC)) uut (.clk(clk), .sys_rst(sys_rst), .ce(ce_in),
        .global_en_pin(en), .ch_above_hi(hi), .ch_below_lo(lo), .ext_above_thr(ext),
        .ov_detect(ov), .sc_detect(sc), .hs_detect(hs), .thermal_hot(hot),
        .drive_rail_low(vlow), .oc_detect(oc), .seq_done(sdone), .seq_blank(sblank),
        .ch_enable(chen), .ext_enable(exen), .cs_enable(csen), .aon_enable(aon),
        .reg_wr(rwr), .reg_rd(rrd), .reg_addr(radr), .reg_wdata(rwd), .reg_rdata(rdat),
        .reg_ack(ack), .power_ok_output(pout), .power_ok_oe_n(poe_n), .ch_run(crun),
        .ext_run(xrun), .cs_run(csrun), .aon_run(arun));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // status byte from live bits and mask
    function automatic logic [7:0] exp_st(input logic [5:0] r, input logic [5:0] k);
        return {&(r | k), 1'b0, r | k};
    endfunction
    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic rd(input logic [7:0] a);
        u_host.xfer(1'b0, a, 8'h00, ok, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, d, ok, q);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // pin level assumes an external pull-up
    task automatic pin(input logic e);
        chk("pin", {7'h0, e}, {7'h0, poe_n ? 1'b1 : pout});
        chk("oe_n", {7'h0, pp ? 1'b0 : (e | ~en)}, {7'h0, poe_n});
    endtask
    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end
    initial begin
        cyc(11);
        chk("rst_out", 8'h00, {crun, xrun, arun});
        @(posedge clk) sys_rst <= 1'b0;
        en <= 1'b1;
        sdone <= 1'b1;
        foreach (q[i]) begin
            if (i < 4) begin
                rd(i == 0 ? ADDR_FAULT : i == 1 ? ADDR_TRIP : i == 2 ? ADDR_MASK : ADDR_CTRL);
                chk("reset_reg", 8'h00, q);
            end
        end
        for (int a = 1; a < 4; a++) begin
            wr(a[7:0], 8'hFF);
            chk("ro_ack", 8'h00, {7'h0, ok});
        end
        rd(8'h30);
        chk("unmapped", 8'h00, q);
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            m = seed[5:0] & {6{seed[6] & seed[7]}};
            pp = seed[8];
            wr(ADDR_MASK, {2'h0, m});
            wr(ADDR_CTRL, {4'h0, pp, 3'h0});
            @(posedge clk);
            hi <= seed[19:16];
            lo <= ~seed[19:16] & seed[23:20];
            ext <= seed[25:24];
            sblank <= &seed[27:26];
            sdone <= ~&seed[30:28];
            st = (st & ~(~seed[19:16] & seed[23:20])) | seed[19:16];
            cyc(4);
            rd(ADDR_STATUS);
            chk("status", exp_st({seed[25:24], st}, m), q);
            pin(exp_st({seed[25:24], st}, m) >> 7 & ~&seed[27:26] & ~&seed[30:28]);
        end
        for (int i = 0; i < 2; i++) begin
            pp = i[0];
            wr(ADDR_CTRL, {4'h0, pp, 3'h0});
            @(posedge clk) en <= 1'b0;
            cyc(4);
            pin(~pp);
            @(posedge clk) en <= 1'b1;
        end
        wr(ADDR_MASK, 8'h00);
        @(posedge clk);
        {hi, lo, ext, sblank, sdone} <= {4'hF, 4'h0, 2'h3, 1'b0, 1'b1};
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            c = seed[1:0];
            @(posedge clk);
            {ov[c], sc[c], hs[c]} <= {k == 0, k == 1, k == 2};
            cyc(3);
            @(posedge clk) {ov, sc, hs} <= 12'h000;
            cyc(4);
            chk("run", {chen & ~(4'h1 << c), 4'h0}, {crun, xrun, 2'h0});
            pin(1'b0);
            wr(ADDR_FAULT, ~(8'h01 << k));
            rd(ADDR_FAULT);
            chk("fault", 8'h01 << k, q);
            wr(ADDR_FAULT, 8'h01 << k);
            cyc(3);
            chk("restart", {chen, exen, 2'h0}, {crun, xrun, 2'h0});
        end
        for (int i = 0; i < NC; i++) begin
            @(posedge clk) oc[i] <= 1'b1;
            cyc(3);
            @(posedge clk) oc <= 3'h0;
            cyc(4);
            chk("cs_run", {chen, 1'b0, csen & ~(3'h1 << i)}, {crun, 1'b0, csrun});
            rd(ADDR_TRIP);
            chk("trip", 8'h01 << i, q);
            wr(ADDR_TRIP, 8'h01 << i);
            cyc(3);
            chk("cs_restart", {5'h0, csen}, {5'h0, csrun});
        end
        @(posedge clk) hot <= 1'b1;
        cyc(4);
        chk("therm_run", {6'h0, aon}, {crun, xrun, arun});
        chk("therm_cs", 8'h00, {5'h0, csrun});
        for (int i = 0; i < 3; i++) begin
            if (i == 1)
                wr(ADDR_FAULT, 8'h08);
            if (i == 2)
                @(posedge clk) hot <= 1'b0;
            cyc(6);
            rd(ADDR_FAULT);
            chk("therm_flag", 8'h08, q);
        end
        chk("therm_stay", 8'h00, {crun, xrun, 2'h0});
        wr(ADDR_FAULT, 8'h08);
        rd(ADDR_FAULT);
        chk("therm_clr", 8'h00, q);
        @(posedge clk) {en, vlow} <= 2'b01;
        cyc(4);
        rd(ADDR_FAULT);
        chk("vdr_off", 8'h00, q);
        @(posedge clk) en <= 1'b1;
        cyc(4);
        chk("vdr_run", {6'h0, aon}, {crun, xrun, arun});
        @(posedge clk) vlow <= 1'b0;
        cyc(4);
        rd(ADDR_FAULT);
        chk("vdr_flag", 8'h10, q);
        wr(ADDR_FAULT, 8'h10);
        rd(ADDR_FAULT);
        chk("vdr_clr", 8'h00, q);
        // frozen clock enable must not capture a heat event
        @(posedge clk) {ce_in, hot} <= 2'b01;
        cyc(6);
        chk("ce_hold", {chen, exen, 2'h0}, {crun, xrun, 2'h0});
        @(posedge clk) {ce_in, hot} <= 2'b10;
        cyc(4);
        rd(ADDR_FAULT);
        chk("ce_resume", 8'h00, q);
        report_and_stop();
    end
endmodule
`default_nettype wire
